// ---- hdl/clpd_avg.sv ----
/*
 clpd_avg: sample history and the averaged value of the window that ended
 one window length ago. assumes tick_in arrives once per 5 ms time base.
*/
`timescale 1ns/1ps
module clpd_avg import clpd_pkg::*; (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// sample stream
	input wire logic tick_in,
	input wire logic [MAG_W-1:0] mag_in,
	// delayed window average
	output logic [MAG_W-1:0] avg_out
);
	clpd_avg_st_t q; // registered state
	clpd_avg_st_t d; // next state
	logic [MAG_W+2:0] sum; // sum of the window ending one window back

	// shift history on each tick; the window is summed from the history before the new sample enters
	always_comb begin
		sum = '0;
		for (int i = AVG_N - 1; i < HIST_N - 1; i++) begin
			sum = sum + q.hist[i];
		end
		d = q;
		if (rst_in) begin
			d = '0;
		end else if (tick_in) begin
			// history keeps the samples needed for the delayed window
			for (int i = HIST_N - 1; i > 0; i--) begin
				d.hist[i] = q.hist[i-1];
			end
			d.hist[0] = mag_in;
			d.avg = MAG_W'(sum / AVG_N);
		end
	end

	// state register
	always_ff @(posedge clock_in) begin
		q <= d;
	end

	assign avg_out = q.avg;
endmodule : clpd_avg

// ---- hdl/clpd_cmp.sv ----
/*
 clpd_cmp: one threshold comparator with a fixed reset ratio.
 assumes tick_in marks fresh magnitudes on the same clock.
*/
`timescale 1ns/1ps
module clpd_cmp import clpd_pkg::*; (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// fresh sample strobe and operands
	input wire logic tick_in,
	input wire logic [MAG_W-1:0] mag_in,
	input wire logic [MAG_W-1:0] thr_in,
	// comparator result
	output logic above_out
);
	clpd_cmp_st_t q; // registered state
	clpd_cmp_st_t d; // next state
	logic [PROD_W-1:0] prod; // setting times reset ratio numerator
	logic [PROD_W-1:0] scaled; // magnitude times reset ratio denominator

	// release level follows the live setting, so group changes act at once;
	// both sides are scaled so the 97 percent level is never rounded down
	always_comb begin
		prod = thr_in * HYST_NUM;
		scaled = mag_in * HYST_DEN;
		d = q;
		if (rst_in) begin
			d = '0;
		end else if (tick_in) begin
			// pick up above setting, drop below the reset level
			if (mag_in > thr_in) begin
				d.above = 1'b1;
			end else if (scaled < prod) begin
				d.above = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge clock_in) begin
		q <= d;
	end

	assign above_out = q.above;
endmodule : clpd_cmp

// ---- hdl/clpd_pkg.sv ----
/*
 clpd_pkg: constants, register map, state and event types of the cold load
 pickup detector. assumes a 40 MHz clock and magnitudes in units of 0.01 x In.
*/
package clpd_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 25;
	localparam int TS_RES_MS = 1;
	localparam int TS_RES_NS = TS_RES_MS * 1_000_000;
	localparam int TS_CYCLES = TS_RES_NS / CLK_PERIOD_NS;
	localparam int TICK_MS = 5;
	// widths and sizes
	localparam int NGROUP = 8;
	localparam int NPHASE = 3;
	localparam int NTHR = 3;
	localparam int NFIELD = 6;
	localparam int MAG_W = 16;
	localparam int TMR_W = 19;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int DIV_W = 16;
	// pre-fault averaging: window length and history depth
	localparam int AVG_MS = 20;
	localparam int AVG_N = AVG_MS / TICK_MS;
	localparam int HIST_N = 2 * AVG_N;
	// reset ratio of every comparator, relative to its setting
	localparam logic [6:0] HYST_NUM = 7'h61;
	localparam logic [6:0] HYST_DEN = 7'h64;
	localparam int PROD_W = MAG_W + 7;
	// setting defaults, thresholds in 0.01 x In
	localparam logic [MAG_W-1:0] LOW_DEF = 16'h0014;
	localparam logic [MAG_W-1:0] HIGH_DEF = 16'h0078;
	localparam logic [MAG_W-1:0] OVER_DEF = 16'h00c8;
	localparam int START_DELAY_DEF_MS = 10000;
	localparam int MAXIMUM_DURATION_DEF_MS = 30000;
	localparam int MINIMUM_DURATION_DEF_MS = 40;
	localparam logic [TMR_W-1:0] START_DELAY_DEF = TMR_W'(START_DELAY_DEF_MS / TICK_MS);
	localparam logic [TMR_W-1:0] MAXIMUM_DURATION_DEF = TMR_W'(MAXIMUM_DURATION_DEF_MS / TICK_MS);
	localparam logic [TMR_W-1:0] MINIMUM_DURATION_DEF = TMR_W'(MINIMUM_DURATION_DEF_MS / TICK_MS);
	// field index inside one setting group
	localparam int FLD_LOW = 0;
	localparam int FLD_HIGH = 1;
	localparam int FLD_OVER = 2;
	localparam int FLD_START_DELAY = 3;
	localparam int FLD_MAXIMUM_DURATION = 4;
	localparam int FLD_MINIMUM_DURATION = 5;
	// register map, word addresses
	localparam logic [ADDR_W-1:0] ADR_CTRL = 7'h00;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 7'h01;
	localparam logic [ADDR_W-1:0] ADR_COUNT = 7'h02;
	localparam logic [ADDR_W-1:0] ADR_PREF = 7'h03;
	localparam logic [ADDR_W-1:0] ADR_TIME = 7'h04;
	localparam logic [ADDR_W-1:0] ADR_BANK = 7'h40;
	// control and status bit positions
	localparam int CTL_GRP_LSB = 0;
	localparam int CTL_TEST_EN = 3;
	localparam int CTL_TEST_SW = 4;
	localparam int CTL_CNT_CLR = 5;
	localparam int STS_ACT = 3;
	localparam int STS_BLK = 4;
	// condition code, values are visible to software
	typedef enum logic [2:0] {
		COND_NORMAL = 3'h0,
		COND_LOW = 3'h1,
		COND_OVER = 3'h2,
		COND_ACTIVE = 3'h3,
		COND_BLOCKED = 3'h4
	} clpd_cond_t;
	// event kinds
	typedef enum logic [1:0] {
		EV_ACT_ON = 2'h0,
		EV_ACT_OFF = 2'h1,
		EV_BLK_ON = 2'h2,
		EV_BLK_OFF = 2'h3
	} clpd_evkind_t;
	// detector states
	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_ACT, ST_BLK} clpd_state_t;
	// three phase magnitudes travel together
	typedef logic [NPHASE-1:0][MAG_W-1:0] clpd_mags_t;
	// one time-stamped event record
	typedef struct packed {
		clpd_evkind_t kind;
		logic [DATA_W-1:0] stamp;
		clpd_mags_t mags;
		clpd_cond_t cond;
	} clpd_event_t;
	// comparator state
	typedef struct packed {
		logic above;
	} clpd_cmp_st_t;
	// averager state
	typedef struct packed {
		logic [HIST_N-1:0][MAG_W-1:0] hist;
		logic [MAG_W-1:0] avg;
	} clpd_avg_st_t;
	// detector state
	typedef struct packed {
		logic blk_s1;
		logic blk_s2;
		logic [NGROUP*NFIELD-1:0][TMR_W-1:0] bank;
		logic [2:0] grp;
		logic test_en;
		logic test_sw;
		logic proc;
		clpd_mags_t smp; // magnitudes taken with the last tick
		clpd_state_t state;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] hi_cnt;
		logic act;
		logic blk;
		clpd_cond_t cond;
		logic [CNT_W-1:0] count;
		logic [MAG_W-1:0] pref;
		logic [DIV_W-1:0] ms_div;
		logic [DATA_W-1:0] stamp;
		clpd_event_t ev;
		logic ev_valid;
		logic [DATA_W-1:0] rdata;
	} clpd_st_t;
endpackage : clpd_pkg

// ---- hdl/clpd_top.sv ----
/*
 clpd_top: cold load pickup detector with setting bank, timers, event
 output, counter and condition code. assumes magnitudes and tick_in come
 from logic on clock_in; block_in is an asynchronous pin.
*/
// Strobed register access and the address map were left to the implementer.
// Operation
// - eight setting groups, one selector, live changes
// - three phase magnitudes, fresh every 5 ms
// - pre-fault average captured at activation
// - comparators release at 97 percent of setting
// - one shared setting per threshold, any phase
// - low condition needs all phases below
// - high condition needs all phases above
// - any phase overcurrent drops activity at once
// - unblocked pickup asserts activity, starts timing
// - block sampled at start of each cycle
// - blocked pickup asserts blocked, nothing more
// - block during activity releases as normal
// - on and off events, 1 ms stamps
// - clearable count of active and blocked
// - blocking event carries currents and fault type
// - condition code zero to four, read only
// - test switch drives block in test mode
// - activity after low persists start delay
// - release after high lasts maximum duration
// - release at normal current only after minimum duration
`timescale 1ns/1ps
module clpd_top import clpd_pkg::*; #(
	parameter int MS_CYCLES = TS_CYCLES // clocks per time stamp step
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// measurement stage
	input wire logic tick_in,
	input wire logic [MAG_W-1:0] phase_a_rms_in,
	input wire logic [MAG_W-1:0] phase_b_rms_in,
	input wire logic [MAG_W-1:0] phase_c_rms_in,
	// blocking pin
	input wire logic block_in,
	// register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rdata_out,
	// function outputs
	output logic cold_load_active_out,
	output logic blocked_out,
	output clpd_cond_t condition_code_out,
	// event stream
	output logic event_valid_out,
	output clpd_event_t event_out
);
	clpd_st_t q; // registered state
	clpd_st_t d; // next state
	clpd_mags_t mags; // live phase magnitudes
	logic [NTHR-1:0][MAG_W-1:0] thr; // active group thresholds
	logic [NTHR-1:0][NPHASE-1:0] above; // comparator flags
	logic [TMR_W-1:0] start_delay; // active start delay in ticks
	logic [TMR_W-1:0] maximum_duration; // active maximum duration in ticks
	logic [TMR_W-1:0] minimum_duration; // active minimum duration in ticks
	logic [MAG_W-1:0] mag_max; // largest phase, fed to the averager
	logic [MAG_W-1:0] pref_avg; // delayed window average
	logic low_cond; // all phases low
	logic high_cond; // all phases high
	logic any_over; // any phase over
	logic blk_now; // effective block this cycle
	logic pick; // pickup in this processing cycle
	logic rel; // release of activity
	logic inc; // count event
	int base; // first bank entry of the active group

	// three phases travel as one word
	assign mags = {phase_c_rms_in, phase_b_rms_in, phase_a_rms_in};

	// the selector picks one group of the bank
	always_comb begin
		base = int'(q.grp) * NFIELD;
		for (int t = 0; t < NTHR; t++) begin
			thr[t] = q.bank[base + t][MAG_W-1:0];
		end
		start_delay = q.bank[base + FLD_START_DELAY];
		maximum_duration = q.bank[base + FLD_MAXIMUM_DURATION];
		minimum_duration = q.bank[base + FLD_MINIMUM_DURATION];
		mag_max = mags[0];
		for (int p = 1; p < NPHASE; p++) begin
			if (mags[p] > mag_max) begin
				mag_max = mags[p];
			end
		end
	end

	// one comparator per threshold and phase, shared setting
	for (genvar g = 0; g < NTHR * NPHASE; g++) begin : g_cmp
		clpd_cmp u_cmp (
			.clock_in(clock_in),
			.rst_in(rst_in),
			.tick_in(tick_in),
			.mag_in(mags[g % NPHASE]),
			.thr_in(thr[g / NPHASE]),
			.above_out(above[g / NPHASE][g % NPHASE])
		);
	end

	// pre-fault history of the largest phase
	clpd_avg u_avg (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.tick_in(tick_in),
		.mag_in(mag_max),
		.avg_out(pref_avg)
	);

	// every phase below the low setting
	assign low_cond = &(~above[FLD_LOW]);
	// every phase above the high setting
	assign high_cond = &above[FLD_HIGH];
	// a single phase above the overcurrent setting
	assign any_over = |above[FLD_OVER];
	// software switch replaces the pin only in test mode
	assign blk_now = q.test_en ? q.test_sw : q.blk_s2;

	// next state: bus, timers, detector and events
	always_comb begin
		d = q;
		pick = 1'b0;
		rel = 1'b0;
		inc = 1'b0;
		d.ev_valid = 1'b0;
		d.rdata = '0;
		// the pin is taken two flops later, source must be early
		d.blk_s1 = block_in;
		d.blk_s2 = q.blk_s1;
		// decide one cycle after the comparators took the sample
		d.proc = tick_in;
		// inputs are valid only with the tick, so keep them for the event
		if (tick_in) begin
			d.smp = mags;
		end
		if (q.ms_div == DIV_W'(MS_CYCLES - 1)) begin
			d.ms_div = '0;
			d.stamp = q.stamp + 1'b1;
		end else begin
			d.ms_div = q.ms_div + 1'b1;
		end
		// register writes
		if (wr_in) begin
			if (addr_in == ADR_CTRL) begin
				d.grp = wdata_in[CTL_GRP_LSB +: 3];
				d.test_en = wdata_in[CTL_TEST_EN];
				d.test_sw = wdata_in[CTL_TEST_SW];
				// clear request, a same-cycle count still lands below
				if (wdata_in[CTL_CNT_CLR]) begin
					d.count = '0;
				end
			end else if (addr_in >= ADR_BANK && addr_in[2:0] < 3'(NFIELD)) begin
				// groups may change while the detector runs
				d.bank[int'(addr_in[5:3]) * NFIELD + int'(addr_in[2:0])] = wdata_in[TMR_W-1:0];
			end
		end
		// register reads, data stand in the next cycle only
		if (rd_in) begin
			if (addr_in == ADR_CTRL) begin
				d.rdata[CTL_GRP_LSB +: 3] = q.grp;
				d.rdata[CTL_TEST_EN] = q.test_en;
				d.rdata[CTL_TEST_SW] = q.test_sw;
			end else if (addr_in == ADR_STATUS) begin
				d.rdata[2:0] = q.cond;
				d.rdata[STS_ACT] = q.act;
				d.rdata[STS_BLK] = q.blk;
			end else if (addr_in == ADR_COUNT) begin
				d.rdata[CNT_W-1:0] = q.count;
			end else if (addr_in == ADR_PREF) begin
				d.rdata[MAG_W-1:0] = q.pref;
			end else if (addr_in == ADR_TIME) begin
				d.rdata = q.stamp;
			end else if (addr_in >= ADR_BANK && addr_in[2:0] < 3'(NFIELD)) begin
				d.rdata[TMR_W-1:0] = q.bank[int'(addr_in[5:3]) * NFIELD + int'(addr_in[2:0])];
			end
		end
		// block is taken at the start of the processing cycle
		if (q.proc) begin
			case (q.state)
				ST_IDLE: begin
					// a zero start delay picks up at once
					if (low_cond) begin
						d.tmr = '0;
						if (start_delay == '0) begin
							pick = 1'b1;
						end else begin
							d.state = ST_ARM;
						end
					end
				end
				ST_ARM: begin
					// low must persist for the start delay
					if (!low_cond) begin
						d.state = ST_IDLE;
					end else begin
						d.tmr = q.tmr + 1'b1;
						if (q.tmr + 1'b1 >= start_delay) begin
							pick = 1'b1;
						end
					end
				end
				ST_ACT: begin
					d.tmr = q.tmr + 1'b1;
					d.hi_cnt = high_cond ? q.hi_cnt + 1'b1 : '0;
					if (any_over) begin
						rel = 1'b1;
					// block during activity ends it as a normal release
					end else if (blk_now) begin
						rel = 1'b1;
					// high current lasted the maximum duration
					end else if (high_cond && q.hi_cnt + 1'b1 >= maximum_duration) begin
						rel = 1'b1;
					// start-up over and minimum duration served
					end else if (!high_cond && !low_cond && q.tmr + 1'b1 >= minimum_duration) begin
						rel = 1'b1;
					end
				end
				ST_BLK: begin
					// blocked pickup ends when the low condition goes away
					if (!low_cond) begin
						d.state = ST_IDLE;
						d.blk = 1'b0;
						d.ev_valid = 1'b1;
						d.ev.kind = EV_BLK_OFF;
					end
				end
				default: begin
					d.state = ST_IDLE;
				end
			endcase
			if (pick) begin
				inc = 1'b1;
				d.ev_valid = 1'b1;
				if (blk_now) begin
					d.state = ST_BLK;
					d.blk = 1'b1;
					d.ev.kind = EV_BLK_ON;
				end else begin
					d.state = ST_ACT;
					d.act = 1'b1;
					d.tmr = '0;
					d.hi_cnt = '0;
					d.ev.kind = EV_ACT_ON;
					// pre-fault value of the delayed window
					d.pref = pref_avg;
				end
			end
			if (rel) begin
				d.state = ST_IDLE;
				d.act = 1'b0;
				d.ev_valid = 1'b1;
				d.ev.kind = EV_ACT_OFF;
			end
			// code from the new outputs and live comparators
			if (d.blk) begin
				d.cond = COND_BLOCKED;
			end else if (d.act) begin
				d.cond = COND_ACTIVE;
			end else if (any_over) begin
				d.cond = COND_OVER;
			end else if (low_cond) begin
				d.cond = COND_LOW;
			end else begin
				d.cond = COND_NORMAL;
			end
			// every event carries currents and fault type
			if (d.ev_valid) begin
				d.ev.stamp = q.stamp;
				d.ev.mags = q.smp;
				d.ev.cond = d.cond;
			end
		end
		// a count in the same cycle as a clear is added after the clear
		if (inc) begin
			d.count = d.count + 1'b1;
		end
		// synchronous reset loads defaults into every group
		if (rst_in) begin
			d = '0;
			for (int g = 0; g < NGROUP; g++) begin
				d.bank[g * NFIELD + FLD_LOW] = TMR_W'(LOW_DEF);
				d.bank[g * NFIELD + FLD_HIGH] = TMR_W'(HIGH_DEF);
				d.bank[g * NFIELD + FLD_OVER] = TMR_W'(OVER_DEF);
				d.bank[g * NFIELD + FLD_START_DELAY] = START_DELAY_DEF;
				d.bank[g * NFIELD + FLD_MAXIMUM_DURATION] = MAXIMUM_DURATION_DEF;
				d.bank[g * NFIELD + FLD_MINIMUM_DURATION] = MINIMUM_DURATION_DEF;
			end
		end
	end

	// single state register
	always_ff @(posedge clock_in) begin
		q <= d;
	end

	// outputs straight from the state register
	assign rdata_out = q.rdata;
	assign cold_load_active_out = q.act;
	assign blocked_out = q.blk;
	assign condition_code_out = q.cond;
	assign event_valid_out = q.ev_valid;
	assign event_out = q.ev;

	property p_over_rel;
		@(posedge clock_in) disable iff (rst_in)
		(q.proc && q.state == ST_ACT && any_over) |=> !q.act;
	endproperty
	a_over_rel: assert property (p_over_rel) else $error("overcurrent kept activity");

	property p_blk_rel;
		@(posedge clock_in) disable iff (rst_in)
		(q.proc && q.state == ST_ACT && blk_now) |=> (!q.act && q.ev.kind == EV_ACT_OFF);
	endproperty
	a_blk_rel: assert property (p_blk_rel) else $error("block did not release");

	property p_blk_only;
		@(posedge clock_in) disable iff (rst_in)
		$rose(q.blk) |-> (!q.act && q.state == ST_BLK);
	endproperty
	a_blk_only: assert property (p_blk_only) else $error("blocked with activity");

	property p_act_low;
		@(posedge clock_in) disable iff (rst_in)
		$rose(q.act) |-> $past(low_cond && q.proc && !blk_now);
	endproperty
	a_act_low: assert property (p_act_low) else $error("activity without low pickup");

	property p_ev_on;
		@(posedge clock_in) disable iff (rst_in)
		$rose(q.act) |-> (q.ev_valid && q.ev.kind == EV_ACT_ON) ##1 !q.ev_valid;
	endproperty
	a_ev_on: assert property (p_ev_on) else $error("missing activity on event");

	property p_count;
		@(posedge clock_in) disable iff (rst_in)
		($rose(q.act) || $rose(q.blk)) |-> q.count != '0;
	endproperty
	a_count: assert property (p_count) else $error("count lost an event");

	property p_cond;
		@(posedge clock_in) disable iff (rst_in)
		(q.blk |-> q.cond == COND_BLOCKED) and (q.act |-> q.cond == COND_ACTIVE);
	endproperty
	a_cond: assert property (p_cond) else $error("condition code mismatch");

	property p_test;
		@(posedge clock_in) disable iff (rst_in)
		(!q.test_en && !$past(rst_in) && !$past(rst_in, 2)) |-> blk_now == $past(block_in, 2);
	endproperty
	a_test: assert property (p_test) else $error("block source wrong outside test");

	property p_proc;
		@(posedge clock_in) disable iff (rst_in)
		tick_in |=> q.proc ##1 (q.cond == (q.blk ? COND_BLOCKED : q.act ? COND_ACTIVE :
			$past(any_over) ? COND_OVER : $past(low_cond) ? COND_LOW : COND_NORMAL));
	endproperty
	a_proc: assert property (p_proc) else $error("sample not processed");

	property p_pref;
		@(posedge clock_in) disable iff (rst_in)
		$rose(q.act) |-> q.pref == $past(pref_avg);
	endproperty
	a_pref: assert property (p_pref) else $error("pre-fault not captured");
endmodule : clpd_top

// ---- test/clpd_meas_model.sv ----
/*
 clpd_meas_model: stand-in for the upstream rms stage, one sample set per
 request after a random latency. assumes go_in pulses on clock_in.
*/
`timescale 1ns/1ps
module clpd_meas_model import clpd_pkg::*; (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// sample request from the bench
	input wire logic go_in,
	input wire clpd_mags_t lvl_in,
	// sample stream
	output logic tick_out,
	output clpd_mags_t mags_out
);
	int seed = 4021; // latency seed, apart from the bench seed
	int wait_q = -1; // cycles left before the tick, -1 when idle
	clpd_mags_t hold_q; // sample waiting to go out
	// one fresh phase set per tick
	always @(posedge clock_in) begin
		if (rst_in) begin
			wait_q <= -1;
			tick_out <= 1'b0;
			mags_out <= '0;
		end else begin
			tick_out <= wait_q == 0;
			// off-tick cycles show the inverse so a stale sample never passes
			mags_out <= (wait_q == 0) ? hold_q : ~mags_out;
			if (go_in) begin
				hold_q <= lvl_in;
				wait_q <= {$random(seed)} % 4;
			end else if (wait_q >= 0) begin
				wait_q <= wait_q - 1;
			end
		end
	end
endmodule : clpd_meas_model

// ---- test/clpd_top_bench.sv ----
/*
 clpd_top_bench: self-checking bench, integer model compared every tick.
 assumes the measurement model in clpd_meas_model and MS_CYCLES of 4.
*/
`timescale 1ns/1ps
module clpd_top_bench import clpd_pkg::*;;
	// stimulus
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic go = 1'b0;
	logic pin = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	clpd_mags_t lvl = '0;
	// observed
	clpd_mags_t mags;
	logic tick, act, blk, evv;
	logic [DATA_W-1:0] rdata, t1, t2;
	clpd_cond_t cond;
	clpd_event_t ev;
	int miscompares = 0;
	int checks = 0;
	int seed = 60899;
	// model: settings, comparator flags, detector state
	int bank[8][6];
	int fl[3][3];
	int grp, ten, tsw, st, tmr, hi, since, cnt, evk, ec, pf, va, vb, vc, band, len, g, tm;
	int hist[$];
	int g5[6] = '{20, 120, 200, 8, 3, 2};
	int bb[4] = '{0, 21, 121, 121}; // band floors
	int bs[4] = '{19, 95, 79, 140}; // band spans

	clpd_meas_model u_clpd_meas_model (.clock_in(clock_in), .rst_in(rst_in), .go_in(go),
		.lvl_in(lvl), .tick_out(tick), .mags_out(mags));
	clpd_top #(.MS_CYCLES(4)) u_clpd_top (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
		.phase_a_rms_in(mags[0]), .phase_b_rms_in(mags[1]), .phase_c_rms_in(mags[2]),
		.block_in(pin), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .cold_load_active_out(act), .blocked_out(blk),
		.condition_code_out(cond), .event_valid_out(evv), .event_out(ev));

	// 40 MHz clock
	initial forever #12.5 clock_in = ~clock_in;

	task results();
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: got %0h, want %0h", $time, seen, exp);
		end
	endtask : check

	// one write cycle; the model follows the same write
	task wreg(input int a, input int d);
		@(posedge clock_in);
		addr <= ADDR_W'(a);
		wdata <= DATA_W'(d);
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
		if (a == 0) begin
			grp = d & 7;
			ten = (d >> 3) & 1;
			tsw = (d >> 4) & 1;
			if ((d >> 5) & 1) cnt = 0;
		end else if (a >= 'h40 && (a & 7) < 6) begin
			bank[(a >> 3) & 7][a & 7] = d & 'h7ffff;
		end
	endtask : wreg

	// one read cycle, data taken in the following cycle
	task rreg(input int a, output logic [DATA_W-1:0] v);
		@(posedge clock_in);
		addr <= ADDR_W'(a);
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg

	task rchk(input int a, input int e);
		logic [DATA_W-1:0] v;
		rreg(a, v);
		check(v, e);
	endtask : rchk

	// detector model for one fresh sample set
	task model(input int a, input int b, input int c);
		int m[3];
		int lowc, highc, overc, pick, bl, n;
		m = '{a, b, c};
		evk = -1;
		pick = 0;
		bl = ten ? tsw : pin;
		// shared setting, release below 97 percent
		for (int p = 0; p < 3; p++) begin
			for (int f = 0; f < 3; f++) begin
				if (m[p] > bank[grp][f]) fl[p][f] = 1;
				else if (m[p] * 100 < bank[grp][f] * 97) fl[p][f] = 0;
			end
		end
		// all low, all high, any over
		lowc = !(fl[0][0] | fl[1][0] | fl[2][0]);
		highc = fl[0][1] & fl[1][1] & fl[2][1];
		overc = fl[0][2] | fl[1][2] | fl[2][2];
		hist.push_back(a > b ? (a > c ? a : c) : (b > c ? b : c));
		n = hist.size();
		case (st)
			0: if (lowc) begin
				tmr = 0;
				if (bank[grp][3] == 0) pick = 1;
				else st = 1;
			end
			1: if (!lowc) st = 0;
			else begin
				tmr++;
				if (tmr >= bank[grp][3]) pick = 1;
			end
			2: begin
				since++;
				hi = highc ? hi + 1 : 0;
				if (overc || bl || hi >= bank[grp][4] ||
					(!highc && !lowc && since >= bank[grp][5])) begin
					st = 0;
					evk = 1;
				end
			end
			default: if (!lowc) begin
				st = 0;
				evk = 3;
			end
		endcase
		if (pick) begin
			st = bl ? 3 : 2;
			evk = bl ? 2 : 0;
			cnt++;
			since = 0;
			hi = 0;
			if (n >= 8 && !bl) pf = (hist[n-8] + hist[n-7] + hist[n-6] + hist[n-5]) / 4;
		end
		ec = st == 2 ? 3 : st == 3 ? 4 : overc ? 2 : lowc ? 1 : 0;
	endtask : model

	// request one sample set and compare at the decision cycle
	task step(input int a, input int b, input int c);
		int n;
		@(posedge clock_in);
		lvl <= {MAG_W'(c), MAG_W'(b), MAG_W'(a)};
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clock_in);
			#1;
			n++;
		end while (tick !== 1'b1 && n < 10);
		if (n >= 10) miscompares++;
		repeat (2) @(posedge clock_in);
		#1;
		model(a, b, c);
		check(act, st == 2);
		check(blk, st == 3);
		check(cond, ec);
		check(evv, evk >= 0);
		if (evk >= 0) begin
			check(ev.kind, evk);
			check(ev.mags, lvl);
			check(ev.cond, ec);
		end
	endtask : step

	initial begin
		for (int i = 0; i < 8; i++) bank[i] = '{20, 120, 200, 2000, 6000, 8};
		repeat (20) @(posedge clock_in);
		rst_in <= 1'b0;
		for (int f = 0; f < 6; f++) rchk('h40 + f, bank[0][f]);
		rchk(ADR_STATUS, 0);
		wreg('h46, 5);
		rchk('h46, 0);
		rchk('h06, 0);
		for (int f = 0; f < 6; f++) begin
			wreg('h68 + f, g5[f]);
			wreg('h50 + f, f == 3 ? 0 : g5[f]);
		end
		wreg(ADR_CTRL, 5);
		rchk('h43, 2000);
		// hysteresis edge, then a full start delay and an overcurrent drop
		step(50, 50, 50);
		step(19, 19, 20);
		repeat (9) step(19, 18, 17);
		rchk(ADR_PREF, pf);
		rchk(ADR_STATUS, 3 | 8);
		step(50, 205, 50);
		// random runs over bands, groups, pin and test switch
		for (int r = 0; r < 60; r++) begin
			band = {$random(seed)} % 4;
			len = 1 + {$random(seed)} % 12;
			va = bb[band] + {$random(seed)} % bs[band];
			vb = bb[band] + {$random(seed)} % bs[band];
			vc = bb[band] + {$random(seed)} % bs[band];
			g = ({$random(seed)} % 2) ? 2 : 5;
			tm = {$random(seed)} % 8;
			// block level settles well before the next tick
			wreg(ADR_CTRL, g | (tm == 0 ? 24 : tm == 1 ? 8 : 0));
			@(posedge clock_in);
			pin <= ({$random(seed)} % 5) == 0;
			repeat (3) @(posedge clock_in);
			repeat (len) step(va, vb, vc);
		end
		rchk(ADR_COUNT, cnt);
		wreg(ADR_CTRL, 32);
		rchk(ADR_COUNT, 0);
		rreg(ADR_TIME, t1);
		repeat (40) @(posedge clock_in);
		rreg(ADR_TIME, t2);
		check((t2 - t1 == 10) || (t2 - t1 == 11), 1);
		results();
	end

	// watchdog, well past the expected run length
	initial begin
		#500000;
		miscompares++;
		results();
	end
endmodule : clpd_top_bench
